// ---- rtl/pmc_top.v ----
// How it works
// - enable bit 15 set activates port; clear means no external access.
// - stop-in-idle bit 13 freezes port activity while device is idle.
// - multiplex 11 puts only low address byte on data bus.
// - multiplex 10 puts both address bytes on data bus, two phases.
// - multiplex 01 muxes low byte; upper bits on lines 10:8, 14.
// - multiplex 00 keeps address and data on separate pins.
// - bit 10 stores input buffer select, TTL when 1, Schmitt when 0.
// - bit 9 enables the write strobe pin, else pin undriven.
// - bit 8 enables the read strobe pin, else pin undriven.
// - chip-select function 10 makes chip select, else address line 14.
// - bit 5 sets both address latch strobes active high or low.
// - polarity and function bits ignored while pin is an address line.
// - bits 31-16, 14, 4 and 2 read zero; writes to them ignored.
`timescale 1ns/100ps
`default_nettype none
`include "pmc_map.vh"

module pmc_top (
  // clock, reset, enable
  input  wire        CLK_IN,
  input  wire        SYS_RST_IN,
  input  wire        CE_IN,
  input  wire        IDLE_IN,
  // axi4-lite write address
  input  wire [7:0]  S_AXI_AWADDR_IN,
  input  wire        S_AXI_AWVALID_IN,
  output wire        S_AXI_AWREADY_OUT,
  // axi4-lite write data
  input  wire [31:0] S_AXI_WDATA_IN,
  input  wire [3:0]  S_AXI_WSTRB_IN,
  input  wire        S_AXI_WVALID_IN,
  output wire        S_AXI_WREADY_OUT,
  // axi4-lite write response
  output wire [1:0]  S_AXI_BRESP_OUT,
  output wire        S_AXI_BVALID_OUT,
  input  wire        S_AXI_BREADY_IN,
  // axi4-lite read address
  input  wire [7:0]  S_AXI_ARADDR_IN,
  input  wire        S_AXI_ARVALID_IN,
  output wire        S_AXI_ARREADY_OUT,
  // axi4-lite read data
  output wire [31:0] S_AXI_RDATA_OUT,
  output wire [1:0]  S_AXI_RRESP_OUT,
  output wire        S_AXI_RVALID_OUT,
  input  wire        S_AXI_RREADY_IN,
  // port data bus
  input  wire [7:0]  PORT_DATA_BUS_IN,
  output wire [7:0]  PORT_DATA_BUS_OUT,
  output wire        PORT_DATA_BUS_OEN_OUT,
  // address, chip select, latches
  output wire [15:0] PORT_ADDRESS_OUT,
  output wire        CHIP_SELECT_PIN_OUT,
  output wire        ADDRESS_LATCH_LOW_STROBE_OUT,
  output wire        ADDRESS_LATCH_HIGH_STROBE_OUT,
  // strobes
  output wire        WRITE_OR_ENABLE_STROBE_OUT,
  output wire        WRITE_OR_ENABLE_STROBE_OEN_OUT,
  output wire        READ_OR_READWRITE_STROBE_OUT,
  output wire        READ_OR_READWRITE_STROBE_OEN_OUT,
  // pad control
  output wire        INPUT_BUFFER_SELECT_OUT
);

  // ****************************************************************
  // constants
  // ****************************************************************
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_ALO  = 3'h1;
  localparam [2:0] ST_AHI  = 3'h2;
  localparam [2:0] ST_DATA = 3'h3;
  localparam [2:0] ST_HOLD = 3'h4;

  localparam integer LATCH_N   = `PMC_NS_TO_CYC(`PMC_LATCH_NS) - 1;
  localparam integer STROBE_N  = `PMC_NS_TO_CYC(`PMC_STROBE_NS) - 1;
  localparam integer HOLD_N    = `PMC_NS_TO_CYC(`PMC_HOLD_NS) - 1;
  localparam [3:0]   LATCH_LD  = LATCH_N[3:0];
  localparam [3:0]   STROBE_LD = STROBE_N[3:0];
  localparam [3:0]   HOLD_LD   = HOLD_N[3:0];

  // ****************************************************************
  // declarations
  // ****************************************************************
  reg  [31:0] ctrl_r;
  reg  [15:0] sw_addr_r;
  reg  [7:0]  sw_wdata_r;
  reg         aw_got_r;
  reg  [7:0]  aw_addr_r;
  reg         w_got_r;
  reg  [31:0] w_data_r;
  reg  [3:0]  w_strb_r;
  reg         bvalid_r;
  reg  [1:0]  bresp_r;
  reg         rvalid_r;
  reg  [1:0]  rresp_r;
  reg  [31:0] rdata_r;
  reg  [2:0]  state_r;
  reg  [2:0]  state_nxt;
  reg  [3:0]  cnt_r;
  reg  [3:0]  cnt_nxt;
  reg         dir_wr_r;
  reg  [15:0] addr_r;
  reg  [7:0]  wdat_r;
  reg  [7:0]  rdat_r;
  reg  [7:0]  dbus_r;
  reg         dbus_oen_r;
  reg  [15:0] pa_r;
  reg         cs_r;
  reg         all_r;
  reg         alh_r;
  reg         wr_r;
  reg         rd_r;
  reg  [7:0]  dbus_nxt;
  reg         dbus_oen_nxt;
  reg  [15:0] pa_nxt;
  reg         cs_nxt;
  reg  [31:0] rd_word;
  reg         rd_hit;
  wire [7:0]  din_sync;
  wire [31:0] byte_mask;
  wire        do_wr;
  wire        wr_hit;
  wire        port_on;
  wire        run_en;
  wire        busy;
  wire        start_wr;
  wire        start_rd;
  wire [1:0]  mux_sel;
  wire [1:0]  csf_sel;
  wire        address_latch_polarity;
  wire        lo_act;
  wire        hi_act;
  wire        wr_act;
  wire        rd_act;

  // ****************************************************************
  // field decode
  // ****************************************************************
  assign port_on = ctrl_r[`PMC_BIT_ON];
  assign mux_sel = ctrl_r[`PMC_MUX_HI:`PMC_MUX_LO];
  assign csf_sel = ctrl_r[`PMC_CSF_HI:`PMC_CSF_LO];
  assign address_latch_polarity     = ctrl_r[`PMC_BIT_ALP];
  assign busy    = (state_r != ST_IDLE);
  // engine halts when idle stop is set and the device idles
  assign run_en  = ~(ctrl_r[`PMC_BIT_STOP_IN_IDLE] & IDLE_IN);

  // ****************************************************************
  // pin synchroniser
  // ****************************************************************
  pmc_sync u_sync (
    .clk_in   (CLK_IN),
    .rst_in   (SYS_RST_IN),
    .ce_in    (CE_IN),
    .pin_in   (PORT_DATA_BUS_IN),
    .sync_out (din_sync)
  );

  // ****************************************************************
  // axi4-lite slave
  // ****************************************************************
  assign S_AXI_AWREADY_OUT = CE_IN & ~aw_got_r & ~bvalid_r;
  assign S_AXI_WREADY_OUT  = CE_IN & ~w_got_r & ~bvalid_r;
  assign S_AXI_ARREADY_OUT = CE_IN & ~rvalid_r;
  assign S_AXI_BVALID_OUT  = bvalid_r;
  assign S_AXI_BRESP_OUT   = bresp_r;
  assign S_AXI_RVALID_OUT  = rvalid_r;
  assign S_AXI_RRESP_OUT   = rresp_r;
  assign S_AXI_RDATA_OUT   = rdata_r;

  assign do_wr  = aw_got_r & w_got_r & ~bvalid_r;
  assign wr_hit = (aw_addr_r == `PMC_OFF_CTRL) |
                  (aw_addr_r == `PMC_OFF_ADDR) |
                  (aw_addr_r == `PMC_OFF_WDATA) |
                  (aw_addr_r == `PMC_OFF_STAT);
  assign byte_mask = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}},
                      {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};

  // transfers start only on an enabled, idle, running port
  assign start_wr = do_wr & (aw_addr_r == `PMC_OFF_WDATA) & w_strb_r[0] &
                    port_on & ~busy & run_en;
  assign start_rd = do_wr & (aw_addr_r == `PMC_OFF_STAT) & w_strb_r[0] &
                    w_data_r[`PMC_STAT_START] & port_on & ~busy &
                    run_en;

  always @* begin
    rd_hit  = 1'b1;
    rd_word = 32'h00000000;
    case (S_AXI_ARADDR_IN)
      `PMC_OFF_CTRL:  rd_word = ctrl_r & `PMC_CTRL_IMPL;
      `PMC_OFF_ADDR:  rd_word = {16'h0000, sw_addr_r};
      `PMC_OFF_WDATA: rd_word = {24'h000000, sw_wdata_r};
      `PMC_OFF_STAT:  rd_word = {16'h0000, rdat_r, 7'h00, busy};
      default:        rd_hit  = 1'b0;
    endcase
  end

  always @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      ctrl_r     <= `PMC_CTRL_RESET;
      sw_addr_r  <= 16'h0000;
      sw_wdata_r <= 8'h00;
      aw_got_r   <= 1'b0;
      aw_addr_r  <= 8'h00;
      w_got_r    <= 1'b0;
      w_data_r   <= 32'h00000000;
      w_strb_r   <= 4'h0;
      bvalid_r   <= 1'b0;
      bresp_r    <= `PMC_RESP_OKAY;
      rvalid_r   <= 1'b0;
      rresp_r    <= `PMC_RESP_OKAY;
      rdata_r    <= 32'h00000000;
    end else if (CE_IN) begin
      if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT) begin
        aw_got_r  <= 1'b1;
        aw_addr_r <= S_AXI_AWADDR_IN;
      end
      if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT) begin
        w_got_r  <= 1'b1;
        w_data_r <= S_AXI_WDATA_IN;
        w_strb_r <= S_AXI_WSTRB_IN;
      end
      if (do_wr) begin
        aw_got_r <= 1'b0;
        w_got_r  <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r  <= wr_hit ? `PMC_RESP_OKAY : `PMC_RESP_SLVERR;
        if (aw_addr_r == `PMC_OFF_CTRL) begin
          ctrl_r <= ((ctrl_r & ~byte_mask) | (w_data_r & byte_mask)) &
                    `PMC_CTRL_IMPL;
        end
        if (aw_addr_r == `PMC_OFF_ADDR) begin
          if (w_strb_r[0]) begin
            sw_addr_r[7:0] <= w_data_r[7:0];
          end
          if (w_strb_r[1]) begin
            sw_addr_r[15:8] <= w_data_r[15:8];
          end
        end
        if ((aw_addr_r == `PMC_OFF_WDATA) && w_strb_r[0]) begin
          sw_wdata_r <= w_data_r[7:0];
        end
      end else if (bvalid_r && S_AXI_BREADY_IN) begin
        bvalid_r <= 1'b0;
      end
      if (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT) begin
        rvalid_r <= 1'b1;
        rdata_r  <= rd_word;
        rresp_r  <= rd_hit ? `PMC_RESP_OKAY : `PMC_RESP_SLVERR;
      end else if (rvalid_r && S_AXI_RREADY_IN) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // access sequencer
  // ****************************************************************
  always @* begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    case (state_r)
      ST_IDLE: begin
        if (start_wr || start_rd) begin
          if (mux_sel == `PMC_MUX_SEPARATE) begin
            state_nxt = ST_DATA;
            cnt_nxt   = STROBE_LD;
          end else begin
            state_nxt = ST_ALO;
            cnt_nxt   = LATCH_LD;
          end
        end
      end
      ST_ALO: begin
        if (cnt_r != 4'h0) begin
          cnt_nxt = cnt_r - 4'h1;
        end else if (mux_sel == `PMC_MUX_FULL) begin
          state_nxt = ST_AHI;
          cnt_nxt   = LATCH_LD;
        end else begin
          state_nxt = ST_DATA;
          cnt_nxt   = STROBE_LD;
        end
      end
      ST_AHI: begin
        if (cnt_r != 4'h0) begin
          cnt_nxt = cnt_r - 4'h1;
        end else begin
          state_nxt = ST_DATA;
          cnt_nxt   = STROBE_LD;
        end
      end
      ST_DATA: begin
        if (cnt_r != 4'h0) begin
          cnt_nxt = cnt_r - 4'h1;
        end else begin
          state_nxt = ST_HOLD;
          cnt_nxt   = HOLD_LD;
        end
      end
      ST_HOLD: begin
        if (cnt_r != 4'h0) begin
          cnt_nxt = cnt_r - 4'h1;
        end else begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
        cnt_nxt   = 4'h0;
      end
    endcase
    // clearing the enable abandons any access in flight
    if (!port_on) begin
      state_nxt = ST_IDLE;
      cnt_nxt   = 4'h0;
    end
  end

  always @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      state_r  <= ST_IDLE;
      cnt_r    <= 4'h0;
      dir_wr_r <= 1'b0;
      addr_r   <= 16'h0000;
      wdat_r   <= 8'h00;
      rdat_r   <= 8'h00;
    end else if (CE_IN && (run_en || !port_on)) begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      if (state_r == ST_IDLE) begin
        dir_wr_r <= start_wr;
        addr_r   <= sw_addr_r;
        // the starting write lands in sw_wdata_r at this same edge
        wdat_r   <= start_wr ? w_data_r[7:0] : sw_wdata_r;
      end
      // synchroniser lag: read data has settled only by the end of hold
      if ((state_r == ST_HOLD) && (cnt_r == 4'h0) && !dir_wr_r) begin
        rdat_r <= din_sync;
      end
    end
  end

  // ****************************************************************
  // pin drive
  // ****************************************************************
  assign lo_act = port_on & (state_r == ST_ALO);
  assign hi_act = port_on & (state_r == ST_AHI);
  assign wr_act = port_on & (state_r == ST_DATA) & dir_wr_r;
  assign rd_act = port_on & (state_r == ST_DATA) & ~dir_wr_r;

  always @* begin
    dbus_nxt     = 8'h00;
    dbus_oen_nxt = 1'b1;
    if (lo_act) begin
      dbus_nxt     = addr_r[7:0];
      dbus_oen_nxt = 1'b0;
    end else if (hi_act) begin
      dbus_nxt     = addr_r[15:8];
      dbus_oen_nxt = 1'b0;
    end else if (port_on && dir_wr_r &&
                 ((state_r == ST_DATA) || (state_r == ST_HOLD))) begin
      dbus_nxt     = wdat_r;
      dbus_oen_nxt = 1'b0;
    end
  end

  always @* begin
    pa_nxt = 16'h0000;
    if (port_on) begin
      case (mux_sel)
        `PMC_MUX_SEPARATE: pa_nxt = addr_r;
        `PMC_MUX_LOW_PINS: pa_nxt = {1'b0, addr_r[14], 3'h0,
                                     addr_r[10:8], 8'h00};
        default:           pa_nxt = 16'h0000;
      endcase
    end
  end

  always @* begin
    if (csf_sel == `PMC_CSF_CHIPSEL) begin
      cs_nxt = (port_on & busy) ~^ ctrl_r[`PMC_BIT_CSP];
    end else begin
      // address line use: polarity has no say here
      cs_nxt = port_on & addr_r[14];
    end
  end

  always @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      dbus_r     <= 8'h00;
      dbus_oen_r <= 1'b1;
      pa_r       <= 16'h0000;
      cs_r       <= 1'b1;
      all_r      <= 1'b1;
      alh_r      <= 1'b1;
      wr_r       <= 1'b1;
      rd_r       <= 1'b1;
    end else if (CE_IN) begin
      dbus_r     <= dbus_nxt;
      dbus_oen_r <= dbus_oen_nxt;
      pa_r       <= pa_nxt;
      cs_r       <= cs_nxt;
      // separate mode has no latch phase, so latches rest inactive
      all_r      <= lo_act ~^ address_latch_polarity;
      alh_r      <= hi_act ~^ address_latch_polarity;
      wr_r       <= wr_act ~^ ctrl_r[`PMC_BIT_WRSP];
      rd_r       <= rd_act ~^ ctrl_r[`PMC_BIT_RDSP];
    end
  end

  assign PORT_DATA_BUS_OUT             = dbus_r;
  assign PORT_DATA_BUS_OEN_OUT         = dbus_oen_r;
  assign PORT_ADDRESS_OUT              = pa_r;
  assign CHIP_SELECT_PIN_OUT           = cs_r;
  assign ADDRESS_LATCH_LOW_STROBE_OUT  = all_r;
  assign ADDRESS_LATCH_HIGH_STROBE_OUT = alh_r;
  assign WRITE_OR_ENABLE_STROBE_OUT    = wr_r;
  assign READ_OR_READWRITE_STROBE_OUT  = rd_r;
  assign WRITE_OR_ENABLE_STROBE_OEN_OUT =
    ~(port_on & ctrl_r[`PMC_BIT_WREN]);
  assign READ_OR_READWRITE_STROBE_OEN_OUT =
    ~(port_on & ctrl_r[`PMC_BIT_RDEN]);
  assign INPUT_BUFFER_SELECT_OUT = ctrl_r[`PMC_BIT_TTL];

endmodule // pmc_top

`default_nettype wire

// ---- rtl/pmc_map.vh ----
`ifndef PMC_MAP_VH
`define PMC_MAP_VH

// ****************************************************************
// register offsets (byte addresses)
// ****************************************************************
`define PMC_OFF_CTRL      8'h00
`define PMC_OFF_ADDR      8'h04
`define PMC_OFF_WDATA     8'h08
`define PMC_OFF_STAT      8'h0c

// ****************************************************************
// control register fields and values
// ****************************************************************
`define PMC_CTRL_RESET    32'h00000000
`define PMC_CTRL_IMPL     32'h0000bfeb
`define PMC_BIT_ON        15
`define PMC_BIT_STOP_IN_IDLE      13
`define PMC_MUX_HI        12
`define PMC_MUX_LO        11
`define PMC_BIT_TTL       10
`define PMC_BIT_WREN      9
`define PMC_BIT_RDEN      8
`define PMC_CSF_HI        7
`define PMC_CSF_LO        6
`define PMC_BIT_ALP       5
`define PMC_BIT_CSP       3
`define PMC_BIT_WRSP      1
`define PMC_BIT_RDSP      0
`define PMC_MUX_SEPARATE  2'h0
`define PMC_MUX_LOW_PINS  2'h1
`define PMC_MUX_FULL      2'h2
`define PMC_MUX_LOW_ONLY  2'h3
`define PMC_CSF_CHIPSEL   2'h2
`define PMC_STAT_BUSY     0
`define PMC_STAT_RD_LO    8
`define PMC_STAT_START    0

// ****************************************************************
// axi responses
// ****************************************************************
`define PMC_RESP_OKAY     2'h0
`define PMC_RESP_SLVERR   2'h2

// ****************************************************************
// timing
// ****************************************************************
`define PMC_CLK_MHZ       125
`define PMC_LATCH_NS      16
`define PMC_STROBE_NS     40
`define PMC_HOLD_NS       8
`define PMC_NS_TO_CYC(ns) (((ns) * `PMC_CLK_MHZ + 999) / 1000)

`endif

// ---- rtl/pmc_sync.v ----
`timescale 1ns/100ps
`default_nettype none

// ****************************************************************
// three-stage pin synchroniser, output moves once stages 2 and 3 agree
// ****************************************************************
module pmc_sync (
  // clock and reset
  input  wire       clk_in,
  input  wire       rst_in,
  input  wire       ce_in,
  // pins
  input  wire [7:0] pin_in,
  output wire [7:0] sync_out
);

  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_bit
      reg s1_r;
      reg s2_r;
      reg s3_r;
      reg out_r;
      always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
          s1_r  <= 1'b0;
          s2_r  <= 1'b0;
          s3_r  <= 1'b0;
          out_r <= 1'b0;
        end else if (ce_in) begin
          s1_r <= pin_in[i];
          s2_r <= s1_r;
          s3_r <= s2_r;
          if (s2_r == s3_r) begin
            out_r <= s3_r;
          end
        end
      end
      assign sync_out[i] = out_r;
    end
  endgenerate

endmodule // pmc_sync

`default_nettype wire

// ---- dv/pmc_monitor.sv ----
`timescale 1ns/100ps
`default_nettype none
module pmc_monitor (
  // clock and reset
  input wire logic        CLK_IN,
  input wire logic        SYS_RST_IN,
  // register bus
  input wire logic        S_AXI_AWVALID_IN,
  input wire logic        S_AXI_AWREADY_OUT,
  input wire logic        S_AXI_WVALID_IN,
  input wire logic        S_AXI_WREADY_OUT,
  input wire logic [1:0]  S_AXI_BRESP_OUT,
  input wire logic        S_AXI_BVALID_OUT,
  input wire logic        S_AXI_BREADY_IN,
  input wire logic        S_AXI_ARVALID_IN,
  input wire logic        S_AXI_ARREADY_OUT,
  input wire logic [31:0] S_AXI_RDATA_OUT,
  input wire logic [1:0]  S_AXI_RRESP_OUT,
  input wire logic        S_AXI_RVALID_OUT,
  input wire logic        S_AXI_RREADY_IN,
  // port pins
  input wire logic        PORT_DATA_BUS_OEN_OUT,
  input wire logic        ADDRESS_LATCH_LOW_STROBE_OUT,
  input wire logic        ADDRESS_LATCH_HIGH_STROBE_OUT
);
  // ****************************************************************
  // sequences and properties
  // ****************************************************************
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (SYS_RST_IN);
  sequence s_wr_taken;
    S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT && S_AXI_WVALID_IN && S_AXI_WREADY_OUT;
  endsequence
  sequence s_rd_taken;
    S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT;
  endsequence
  sequence s_r_wait;
    S_AXI_RVALID_OUT && !S_AXI_RREADY_IN;
  endsequence
  a_write_answer: assert property (s_wr_taken |=> ##1 S_AXI_BVALID_OUT)
    else $error("write response late");
  a_read_answer: assert property (s_rd_taken |=> S_AXI_RVALID_OUT)
    else $error("read response late");
  a_rdata_hold: assert property (s_r_wait |=>
    S_AXI_RVALID_OUT && $stable(S_AXI_RDATA_OUT) && $stable(S_AXI_RRESP_OUT))
    else $error("read data dropped");
  a_bresp_hold: assert property (S_AXI_BVALID_OUT && !S_AXI_BREADY_IN |=>
    S_AXI_BVALID_OUT && $stable(S_AXI_BRESP_OUT))
    else $error("write response dropped");
  a_read_refused: assert property (S_AXI_RVALID_OUT |-> !S_AXI_ARREADY_OUT)
    else $error("read taken while busy");
  a_slverr_zero: assert property (S_AXI_RVALID_OUT &&
    S_AXI_RRESP_OUT == 2'h2 |-> S_AXI_RDATA_OUT == 32'h0)
    else $error("error read carries data");
  a_latch_pair: assert property (PORT_DATA_BUS_OEN_OUT |->
    ADDRESS_LATCH_LOW_STROBE_OUT == ADDRESS_LATCH_HIGH_STROBE_OUT)
    else $error("latch strobes disagree");
  a_reset_idle: assert property ($fell(SYS_RST_IN) |->
    PORT_DATA_BUS_OEN_OUT && ADDRESS_LATCH_LOW_STROBE_OUT &&
    ADDRESS_LATCH_HIGH_STROBE_OUT)
    else $error("pins active after reset");
endmodule // pmc_monitor
bind pmc_top pmc_monitor i_mon (.*);
`default_nettype wire

// ---- dv/pmc_far_dev.sv ----
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// byte-wide peripheral with active-low strobes and latches
// ****************************************************************
module pmc_far_dev (
  // clock
  input  wire logic        clk_in,
  // pins from the port
  input  wire logic [7:0]  bus_in,
  input  wire logic        bus_en_n_in,
  input  wire logic        lat_lo_n_in,
  input  wire logic        lat_hi_n_in,
  input  wire logic        wr_n_in,
  input  wire logic        rd_n_in,
  input  wire logic [15:0] addr_in,
  // read value and what was seen
  input  wire logic [7:0]  rd_val_in,
  output logic      [7:0]  bus_out,
  output logic      [7:0]  lo_out,
  output logic      [7:0]  hi_out,
  output logic      [7:0]  wdat_out,
  output logic      [15:0] apin_out
);
  logic [7:0] last_r = 8'h00;
  // released bus toggles so a late sample cannot look valid
  assign bus_out = (!rd_n_in && bus_en_n_in) ? rd_val_in : ~last_r;
  always @(posedge clk_in) begin
    last_r <= bus_out;
    if (!lat_lo_n_in && !bus_en_n_in) lo_out <= bus_in;
    if (!lat_hi_n_in && !bus_en_n_in) hi_out <= bus_in;
    if (!wr_n_in && !bus_en_n_in) begin
      wdat_out <= bus_in;
      apin_out <= addr_in;
    end
  end
endmodule // pmc_far_dev
`default_nettype wire

// ---- dv/test_parallel_master_port_control.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "pmc_map.vh"
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin mismatches++; \
  $display("[ERR] %0t got %h want %h", $time, a, b); end end
module test_parallel_master_port_control;
  // ****************************************************************
  // signals
  // ****************************************************************
  logic        CLK_IN = 1'h0, SYS_RST_IN = 1'h1, CE_IN = 1'h1, IDLE_IN = 1'h0;
  logic [7:0]  S_AXI_AWADDR_IN = 8'h0, S_AXI_ARADDR_IN = 8'h0, PORT_DATA_BUS_IN;
  logic [31:0] S_AXI_WDATA_IN = 32'h0, S_AXI_RDATA_OUT, rd;
  logic [3:0]  S_AXI_WSTRB_IN = 4'hf;
  logic        S_AXI_AWVALID_IN = 1'h0, S_AXI_WVALID_IN = 1'h0;
  logic        S_AXI_ARVALID_IN = 1'h0, S_AXI_BREADY_IN = 1'h0;
  logic        S_AXI_RREADY_IN = 1'h0, S_AXI_BVALID_OUT, S_AXI_RVALID_OUT;
  logic        S_AXI_AWREADY_OUT, S_AXI_WREADY_OUT, S_AXI_ARREADY_OUT;
  logic [1:0]  S_AXI_BRESP_OUT, S_AXI_RRESP_OUT;
  logic [7:0]  PORT_DATA_BUS_OUT, m_lo, m_hi, m_wdat;
  logic [15:0] PORT_ADDRESS_OUT, m_apin;
  logic        PORT_DATA_BUS_OEN_OUT, CHIP_SELECT_PIN_OUT, INPUT_BUFFER_SELECT_OUT;
  logic        ADDRESS_LATCH_LOW_STROBE_OUT, ADDRESS_LATCH_HIGH_STROBE_OUT;
  logic        WRITE_OR_ENABLE_STROBE_OUT, WRITE_OR_ENABLE_STROBE_OEN_OUT;
  logic        READ_OR_READWRITE_STROBE_OUT, READ_OR_READWRITE_STROBE_OEN_OUT;
  int          mismatches = 0, total_checks = 0;
  int          lo_n = 0, hi_n = 0, drv_n = 0, cyc = 0;
  localparam logic [7:0] reg_ctl = `PMC_OFF_CTRL, reg_adr = `PMC_OFF_ADDR;
  localparam logic [7:0] reg_wd = `PMC_OFF_WDATA, reg_st = `PMC_OFF_STAT;
  localparam logic [1:0] rsp_ok = `PMC_RESP_OKAY, rsp_err = `PMC_RESP_SLVERR;
  always #4 CLK_IN = ~CLK_IN;
  pmc_top i_dut (.*);
  pmc_far_dev i_far (.clk_in(CLK_IN), .bus_in(PORT_DATA_BUS_OUT),
    .bus_en_n_in(PORT_DATA_BUS_OEN_OUT), .addr_in(PORT_ADDRESS_OUT),
    .lat_lo_n_in(ADDRESS_LATCH_LOW_STROBE_OUT), .rd_val_in(8'h96),
    .lat_hi_n_in(ADDRESS_LATCH_HIGH_STROBE_OUT), .bus_out(PORT_DATA_BUS_IN),
    .wr_n_in(WRITE_OR_ENABLE_STROBE_OUT), .rd_n_in(READ_OR_READWRITE_STROBE_OUT),
    .lo_out(m_lo), .hi_out(m_hi), .wdat_out(m_wdat), .apin_out(m_apin));
  // counts cycles with each latch strobe low and cycles with the bus driven or the write strobe low, and cuts a hang short
  always @(posedge CLK_IN) begin
    cyc <= cyc + 1;
    if (ADDRESS_LATCH_LOW_STROBE_OUT === 1'h0) lo_n <= lo_n + 1;
    if (ADDRESS_LATCH_HIGH_STROBE_OUT === 1'h0) hi_n <= hi_n + 1;
    if (PORT_DATA_BUS_OEN_OUT !== 1'h1 || WRITE_OR_ENABLE_STROBE_OUT !== 1'h1)
      drv_n <= drv_n + 1;
    if (cyc == 20000) begin
      mismatches++;
      close_out;
    end
  end
  // ****************************************************************
  // bus tasks
  // ****************************************************************
  task automatic axw(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er);
    S_AXI_AWADDR_IN <= a;
    S_AXI_WDATA_IN <= d;
    S_AXI_AWVALID_IN <= 1'h1;
    S_AXI_WVALID_IN <= 1'h1;
    do begin
      @(posedge CLK_IN);
      if (S_AXI_AWREADY_OUT) S_AXI_AWVALID_IN <= 1'h0;
      if (S_AXI_WREADY_OUT) S_AXI_WVALID_IN <= 1'h0;
    end while (S_AXI_AWVALID_IN && !S_AXI_AWREADY_OUT ||
               S_AXI_WVALID_IN && !S_AXI_WREADY_OUT);
    while (!S_AXI_BVALID_OUT) @(posedge CLK_IN);
    S_AXI_BREADY_IN <= 1'h1;
    @(posedge CLK_IN);
    `CHK(S_AXI_BRESP_OUT, er)
    S_AXI_BREADY_IN <= 1'h0;
  endtask
  task automatic axr(input logic [7:0] a, input logic [1:0] er);
    S_AXI_ARADDR_IN <= a;
    S_AXI_ARVALID_IN <= 1'h1;
    do @(posedge CLK_IN); while (!S_AXI_ARREADY_OUT);
    S_AXI_ARVALID_IN <= 1'h0;
    while (!S_AXI_RVALID_OUT) @(posedge CLK_IN);
    S_AXI_RREADY_IN <= 1'h1;
    @(posedge CLK_IN);
    rd = S_AXI_RDATA_OUT;
    `CHK(S_AXI_RRESP_OUT, er)
    S_AXI_RREADY_IN <= 1'h0;
  endtask
  task automatic wait_idle;
    int n = 0;
    do begin
      axr(reg_st, rsp_ok);
      n++;
    end while (rd[0] !== 1'h0 && n < 40);
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset;
    axr(reg_ctl, rsp_ok);
    `CHK(rd, `PMC_CTRL_RESET)
    `CHK({PORT_DATA_BUS_OEN_OUT, WRITE_OR_ENABLE_STROBE_OEN_OUT, READ_OR_READWRITE_STROBE_OEN_OUT, ADDRESS_LATCH_LOW_STROBE_OUT, ADDRESS_LATCH_HIGH_STROBE_OUT, INPUT_BUFFER_SELECT_OUT}, 6'h3e)
    $display("reset test done");
  endtask
  task automatic t_regs;
    axw(reg_ctl, 32'hffffffff, rsp_ok);
    axr(reg_ctl, rsp_ok);
    `CHK(rd, `PMC_CTRL_IMPL)
    `CHK(INPUT_BUFFER_SELECT_OUT, 1'h1)
    axw(reg_ctl, 32'h0, rsp_ok);
    `CHK(INPUT_BUFFER_SELECT_OUT, 1'h0)
    axr(8'h10, rsp_err);
    `CHK(rd, 32'h0)
    axw(8'h10, 32'h1, rsp_err);
    $display("register test done");
  endtask
  task automatic t_pins;
    axw(reg_ctl, 32'h8320, rsp_ok);
    `CHK(WRITE_OR_ENABLE_STROBE_OEN_OUT, 1'h0)
    `CHK(READ_OR_READWRITE_STROBE_OEN_OUT, 1'h0)
    `CHK({ADDRESS_LATCH_LOW_STROBE_OUT, ADDRESS_LATCH_HIGH_STROBE_OUT}, 2'h0)
    axw(reg_ctl, 32'h0, rsp_ok);
    `CHK({WRITE_OR_ENABLE_STROBE_OEN_OUT, READ_OR_READWRITE_STROBE_OEN_OUT}, 2'h3)
    `CHK({ADDRESS_LATCH_LOW_STROBE_OUT, ADDRESS_LATCH_HIGH_STROBE_OUT}, 2'h3)
    $display("pin enable test done");
  endtask
  task automatic t_cs;
    axw(reg_adr, 32'h4000, rsp_ok);
    axw(reg_ctl, 32'h8000, rsp_ok);
    `CHK(CHIP_SELECT_PIN_OUT, 1'h1)
    axw(reg_adr, 32'h0, rsp_ok);
    axw(reg_ctl, 32'h8040, rsp_ok);
    `CHK(CHIP_SELECT_PIN_OUT, 1'h0)
    axw(reg_ctl, 32'h8080, rsp_ok);
    `CHK(CHIP_SELECT_PIN_OUT, 1'h1)
    axw(reg_ctl, 32'h8088, rsp_ok);
    `CHK(CHIP_SELECT_PIN_OUT, 1'h0)
    $display("chip select test done");
  endtask
  task automatic t_mux;
    int blo;
    int bhi;
    axw(reg_adr, 32'h4a5c, rsp_ok);
    for (int i = 0; i < 4; i++) begin
      axw(reg_ctl, 32'h8300 | (i << 11), rsp_ok);
      blo = lo_n;
      bhi = hi_n;
      axw(reg_wd, 32'h3c + i, rsp_ok);
      wait_idle;
      `CHK(m_wdat, 8'h3c + i[7:0])
      `CHK(lo_n - blo, (i != 0) ? 2 : 0)
      `CHK(hi_n - bhi, (i == 2) ? 2 : 0)
      if (i == 0) `CHK(m_apin, 16'h4a5c)
      if (i == 1) `CHK({m_apin[14], m_apin[10:8]}, 4'ha)
      if (i != 0) `CHK(m_lo, 8'h5c)
      if (i == 2) `CHK(m_hi, 8'h4a)
    end
    axw(reg_st, 32'h1, rsp_ok);
    wait_idle;
    `CHK(rd[15:8], 8'h96)
    $display("multiplex test done");
  endtask
  task automatic t_off;
    int b;
    axw(reg_ctl, 32'h300, rsp_ok);
    b = drv_n;
    axw(reg_wd, 32'h11, rsp_ok);
    axr(reg_st, rsp_ok);
    `CHK(rd[0], 1'h0)
    `CHK(drv_n - b, 0)
    `CHK(m_wdat, 8'h3f)
    $display("disable test done");
  endtask
  task automatic t_idle;
    int b;
    IDLE_IN <= 1'h1;
    axw(reg_ctl, 32'ha300, rsp_ok);
    b = drv_n;
    axw(reg_wd, 32'h21, rsp_ok);
    wait_idle;
    `CHK(drv_n - b, 0)
    axw(reg_ctl, 32'h8300, rsp_ok);
    axw(reg_wd, 32'h22, rsp_ok);
    wait_idle;
    `CHK(m_wdat, 8'h22)
    IDLE_IN <= 1'h0;
    $display("idle test done");
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge CLK_IN);
    SYS_RST_IN <= 1'h0;
    @(posedge CLK_IN);
    t_reset;
    t_regs;
    t_pins;
    t_cs;
    t_mux;
    t_off;
    t_idle;
    close_out;
  end
endmodule // test_parallel_master_port_control
`default_nettype wire
